// >>> core/msi_aer_pkg.sv
// Constants shared by the interrupt-message and error-reporting register bank
`default_nettype none
package msi_aer_pkg;
    localparam int ADDR_W = 12;

    localparam logic [11:0] MSG_CTRL_OFF  = 12'h0f0;
    localparam logic [11:0] ADDR_LO_OFF   = 12'h0f4;
    localparam logic [11:0] ADDR_HI_OFF   = 12'h0f8;
    localparam logic [11:0] PAYLOAD_OFF   = 12'h0fc;
    localparam logic [11:0] AER_HDR_OFF   = 12'h100;
    localparam logic [11:0] UE_STAT_OFF   = 12'h104;
    localparam logic [11:0] UE_MASK_OFF   = 12'h108;
    localparam logic [11:0] UE_SEV_OFF    = 12'h10c;
    localparam logic [11:0] CE_STAT_OFF   = 12'h110;
    localparam logic [11:0] IRQ_STAT_OFF  = 12'h1f0;
    localparam logic [11:0] IRQ_CLR_OFF   = 12'h1f4;
    localparam logic [11:0] IRQ_EN_OFF    = 12'h1f8;

    localparam int MSI_EN_BIT = 16;
    localparam int MMC_LSB    = 17;
    localparam int MME_LSB    = 20;
    localparam int CAP64_BIT  = 23;
    localparam int ADDR_LO_LSB = 2;
    localparam logic [7:0] MSI_CAP_ID = 8'h05;
    localparam logic [7:0] MSI_NEXT   = 8'h00;
    localparam logic [2:0] MMC_VAL    = 3'h0;
    localparam logic [2:0] MME_MAX    = 3'h5;
    localparam logic [2:0] MME_RST    = 3'h0;
    localparam logic       MSI_EN_RST = 1'b0;
    localparam logic       CAP64_RST  = 1'b1;

    localparam logic [15:0] AER_ID   = 16'h0001;
    localparam logic [3:0]  AER_VER  = 4'h1;
    localparam logic [11:0] AER_NEXT = 12'h150;

    localparam logic [31:0] UE_VALID   = 32'h001ff011;
    localparam logic [31:0] UE_SEV_RST = 32'h00062011;
    localparam logic [31:0] CE_VALID   = 32'h000011c1;
    localparam logic [31:0] ZERO_RST   = 32'h00000000;

    localparam int IRQ_W       = 3;
    localparam int IRQ_UE_BIT  = 0;
    localparam int IRQ_CE_BIT  = 1;
    localparam int IRQ_MSG_BIT = 2;
endpackage : msi_aer_pkg
`default_nettype wire

// >>> core/msg_req_if.sv
// Request carrier between the register bank and the interrupt-message writer
`default_nettype none
interface msg_req_if;
    logic        req;
    logic        take;
    logic        done;
    logic [63:0] addr;
    logic [15:0] data;
    modport regs   (output req, output addr, output data, input take, input done);
    modport writer (input req, input addr, input data, output take, output done);
endinterface : msg_req_if
`default_nettype wire

// >>> core/msi_msg_writer.sv
// Issues one memory-write interrupt message per accepted request
`default_nettype none
module msi_msg_writer
(
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         warm_rst,
    msg_req_if.writer         req_if,
    output logic              mw_valid,
    input  wire logic         mw_ready,
    output logic [63:0]       mw_addr,
    output logic [31:0]       mw_data
);
    import msi_aer_pkg::*;

    typedef enum logic [1:0] {
        W_IDLE = 2'b01,
        W_SEND = 2'b10
    } wstate_t;

    typedef struct packed {
        wstate_t     st;
        logic [63:0] addr;
        logic [31:0] data;
    } wregs_t;

    wregs_t s_q;
    wregs_t s_d;

    always_comb
    begin
        s_d = s_q;
        req_if.take = 1'b0;
        req_if.done = 1'b0;
        case (s_q.st)
            W_IDLE:
            begin
                // Snapshot address and data so later register writes cannot tear a message
                if (req_if.req)
                begin
                    req_if.take = 1'b1;
                    s_d.addr    = req_if.addr;
                    s_d.data    = {16'h0000, req_if.data};
                    s_d.st      = W_SEND;
                end
            end
            W_SEND:
            begin
                if (mw_ready)
                begin
                    req_if.done = 1'b1;
                    s_d.st      = W_IDLE;
                end
            end
            default:
            begin
                s_d.st = W_IDLE;
            end
        endcase
        if (warm_rst)
        begin
            s_d.st = W_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= '{st: W_IDLE, addr: 64'h0, data: 32'h0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign mw_valid = (s_q.st == W_SEND);
    assign mw_addr  = s_q.addr;
    assign mw_data  = s_q.data;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_take;
        req_if.req && (s_q.st == W_IDLE) && !warm_rst;
    endsequence

    AST_MSG_ISSUE: assert property (s_take |=> mw_valid && mw_addr == $past(req_if.addr))
        else $error("message write not issued to programmed address");
    AST_MSG_HOLD: assert property (mw_valid && !mw_ready && !warm_rst |=> mw_valid && $stable(mw_data))
        else $error("message write dropped before acceptance");
endmodule : msi_msg_writer
`default_nettype wire

// >>> core/msi_and_error_report_regs.sv
// Interrupt-message and error-reporting configuration register bank
//
// Chosen here: the strobed register port.
`default_nettype none
module msi_and_error_report_regs
(
    input  wire logic                           clk,
    input  wire logic                           rst_b,
    input  wire logic                           warm_rst,
    input  wire logic [msi_aer_pkg::ADDR_W-1:0] addr,
    input  wire logic [31:0]                    wdata,
    input  wire logic                           wr,
    input  wire logic                           rd,
    output logic [31:0]                         rdata,
    input  wire logic [31:0]                    ue_event,
    input  wire logic [31:0]                    ce_event,
    output logic                                err_fatal,
    output logic                                err_nonfatal,
    output logic                                err_corr,
    input  wire logic                           intx_in_b,
    output logic                                intx_out_b,
    output logic                                irq,
    output logic                                mw_valid,
    input  wire logic                           mw_ready,
    output logic [63:0]                         mw_addr,
    output logic [31:0]                         mw_data
);
    import msi_aer_pkg::*;

    typedef struct packed {
        logic             msi_en;
        logic [2:0]       mme;
        logic             cap64;
        logic [29:0]      addr_lo;
        logic [31:0]      addr_hi;
        logic [15:0]      payload;
        logic [31:0]      ue_stat;
        logic [31:0]      ue_mask;
        logic [31:0]      ue_sev;
        logic [31:0]      ce_stat;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_en;
        logic [31:0]      rdata;
        logic             err_fatal;
        logic             err_nonfatal;
        logic             err_corr;
        logic             trig_prev;
        logic             pend;
        logic             intx_s1;
        logic             intx_s2;
    } regs_t;

    localparam regs_t REGS_RST = '{
        msi_en:       MSI_EN_RST,
        mme:          MME_RST,
        cap64:        CAP64_RST,
        addr_lo:      30'h0,
        addr_hi:      ZERO_RST,
        payload:      16'h0,
        ue_stat:      ZERO_RST,
        ue_mask:      ZERO_RST,
        ue_sev:       UE_SEV_RST,
        ce_stat:      ZERO_RST,
        irq_stat:     3'h0,
        irq_en:       3'h0,
        rdata:        ZERO_RST,
        err_fatal:    1'b0,
        err_nonfatal: 1'b0,
        err_corr:     1'b0,
        trig_prev:    1'b0,
        pend:         1'b0,
        intx_s1:      1'b1,
        intx_s2:      1'b1
    };

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction : hit

    // Set wins over clear so an event in the clearing cycle is kept
    function automatic logic [31:0] w1c(input logic [31:0] old,
                                        input logic [31:0] set,
                                        input logic [31:0] clr);
        w1c = (old & ~clr) | set;
    endfunction : w1c

    regs_t            s_q;
    regs_t            s_d;
    msg_req_if        req_if ();
    logic             wr_ok;
    logic [31:0]      ue_set;
    logic [31:0]      ce_set;
    logic [31:0]      ue_report;
    logic [IRQ_W-1:0] irq_evt;
    logic [IRQ_W-1:0] irq_clr;
    logic             irq_w;
    logic             trig;
    logic [31:0]      ue_clr_expect;
    logic [31:0]      ce_clr_expect;
    logic [31:0]      irq_next;

    // Bus writes are dropped while warm reset is held, sticky ones included
    assign wr_ok     = wr && !warm_rst;
    assign ue_set    = ue_event & UE_VALID;
    assign ce_set    = ce_event & CE_VALID;
    assign ue_report = ue_set & ~s_q.ue_mask;
    assign irq_w     = |(s_q.irq_stat & s_q.irq_en);
    assign trig      = s_q.msi_en && irq_w;
    assign ue_clr_expect = s_q.ue_stat & ~wdata;
    assign ce_clr_expect = s_q.ce_stat & ~wdata;
    assign irq_next      = w1c({29'h0, s_q.irq_stat}, {29'h0, irq_evt}, {29'h0, irq_clr});

    always_comb
    begin
        irq_evt              = '0;
        irq_evt[IRQ_UE_BIT]  = |ue_report;
        irq_evt[IRQ_CE_BIT]  = |ce_set;
        irq_evt[IRQ_MSG_BIT] = req_if.done;
        irq_clr              = (wr_ok && hit(addr, IRQ_CLR_OFF)) ? wdata[IRQ_W-1:0] : '0;
    end

    always_comb
    begin
        s_d = s_q;
        s_d.intx_s1 = intx_in_b;
        s_d.intx_s2 = s_q.intx_s1;

        s_d.err_fatal    = |(ue_report & s_q.ue_sev);
        s_d.err_nonfatal = |(ue_report & ~s_q.ue_sev);
        s_d.err_corr     = |ce_set;

        s_d.ue_stat  = w1c(s_q.ue_stat, ue_set,
                           (wr_ok && hit(addr, UE_STAT_OFF)) ? wdata & UE_VALID : 32'h0);
        s_d.ce_stat  = w1c(s_q.ce_stat, ce_set,
                           (wr_ok && hit(addr, CE_STAT_OFF)) ? wdata & CE_VALID : 32'h0);
        s_d.irq_stat = irq_next[IRQ_W-1:0];

        if (wr_ok && hit(addr, MSG_CTRL_OFF))
        begin
            s_d.msi_en = wdata[MSI_EN_BIT];
            s_d.cap64  = wdata[CAP64_BIT];
            // Reserved counts are refused and the old allocation kept
            if (wdata[MME_LSB +: 3] <= MME_MAX)
            begin
                s_d.mme = wdata[MME_LSB +: 3];
            end
        end
        if (wr_ok && hit(addr, ADDR_LO_OFF))
        begin
            s_d.addr_lo = wdata[31:ADDR_LO_LSB];
        end
        if (wr_ok && hit(addr, ADDR_HI_OFF))
        begin
            s_d.addr_hi = wdata;
        end
        if (wr_ok && hit(addr, PAYLOAD_OFF))
        begin
            s_d.payload = wdata[15:0];
        end
        if (wr_ok && hit(addr, UE_MASK_OFF))
        begin
            s_d.ue_mask = wdata & UE_VALID;
        end
        if (wr_ok && hit(addr, UE_SEV_OFF))
        begin
            s_d.ue_sev = wdata & UE_VALID;
        end
        if (wr_ok && hit(addr, IRQ_EN_OFF))
        begin
            s_d.irq_en = wdata[IRQ_W-1:0];
        end

        // A new rising request while one waits merges into it
        s_d.trig_prev = trig;
        s_d.pend      = (trig && !s_q.trig_prev) || (s_q.pend && !req_if.take);

        s_d.rdata = 32'h0;
        if (rd)
        begin
            case (addr)
                MSG_CTRL_OFF: s_d.rdata = {8'h00, s_q.cap64, s_q.mme, MMC_VAL,
                                           s_q.msi_en, MSI_NEXT, MSI_CAP_ID};
                ADDR_LO_OFF:  s_d.rdata = {s_q.addr_lo, 2'b00};
                ADDR_HI_OFF:  s_d.rdata = s_q.addr_hi;
                PAYLOAD_OFF:  s_d.rdata = {16'h0000, s_q.payload};
                AER_HDR_OFF:  s_d.rdata = {AER_NEXT, AER_VER, AER_ID};
                UE_STAT_OFF:  s_d.rdata = s_q.ue_stat;
                UE_MASK_OFF:  s_d.rdata = s_q.ue_mask;
                UE_SEV_OFF:   s_d.rdata = s_q.ue_sev;
                CE_STAT_OFF:  s_d.rdata = s_q.ce_stat;
                IRQ_STAT_OFF: s_d.rdata = {29'h0, s_q.irq_stat};
                IRQ_EN_OFF:   s_d.rdata = {29'h0, s_q.irq_en};
                default:      s_d.rdata = 32'h0;
            endcase
        end

        // Warm reset spares the sticky error registers
        if (warm_rst)
        begin
            s_d.msi_en    = REGS_RST.msi_en;
            s_d.mme       = REGS_RST.mme;
            s_d.cap64     = REGS_RST.cap64;
            s_d.addr_lo   = REGS_RST.addr_lo;
            s_d.addr_hi   = REGS_RST.addr_hi;
            s_d.payload   = REGS_RST.payload;
            s_d.irq_stat  = REGS_RST.irq_stat;
            s_d.irq_en    = REGS_RST.irq_en;
            s_d.trig_prev = REGS_RST.trig_prev;
            s_d.pend      = REGS_RST.pend;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= REGS_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign req_if.req  = s_q.pend;
    assign req_if.addr = {s_q.cap64 ? s_q.addr_hi : 32'h0, s_q.addr_lo, 2'b00};
    assign req_if.data = s_q.payload;

    msi_msg_writer u_writer
    (
        .clk      (clk),
        .rst_b    (rst_b),
        .warm_rst (warm_rst),
        .req_if   (req_if),
        .mw_valid (mw_valid),
        .mw_ready (mw_ready),
        .mw_addr  (mw_addr),
        .mw_data  (mw_data)
    );

    assign rdata        = s_q.rdata;
    assign err_fatal    = s_q.err_fatal;
    assign err_nonfatal = s_q.err_nonfatal;
    assign err_corr     = s_q.err_corr;
    assign irq          = irq_w;
    // Downstream pin interrupts pass only in legacy mode
    assign intx_out_b   = s_q.msi_en || (!irq_w && s_q.intx_s2);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_hi_write;
        wr && !warm_rst && addr == ADDR_HI_OFF;
    endsequence
    sequence s_hi_read;
        rd && !warm_rst && addr == ADDR_HI_OFF;
    endsequence
    sequence s_lo_write;
        wr && !warm_rst && addr == ADDR_LO_OFF;
    endsequence
    sequence s_lo_read;
        rd && !warm_rst && addr == ADDR_LO_OFF;
    endsequence
    sequence s_pl_write;
        wr && !warm_rst && addr == PAYLOAD_OFF;
    endsequence
    sequence s_pl_read;
        rd && !warm_rst && addr == PAYLOAD_OFF;
    endsequence

    AST_INTX_MUTE: assert property (s_q.msi_en |-> intx_out_b)
        else $error("legacy pin asserted in message mode");
    AST_MMC_READ: assert property (rd && addr == MSG_CTRL_OFF |=> rdata[19:17] == 3'h0)
        else $error("message count capability not zero");
    AST_MME_RESERVED: assert property (wr && !warm_rst && addr == MSG_CTRL_OFF
        && wdata[22:20] > 3'h5 |=> $stable(s_q.mme))
        else $error("reserved allocation code accepted");
    AST_ADDR_LO_ALIGN: assert property (rd && addr == ADDR_LO_OFF |=> rdata[1:0] == 2'b00)
        else $error("low address bits not zero");
    // The master leaves one idle cycle between a write and the next read
    AST_ADDR_HI_RW: assert property (s_hi_write ##2 s_hi_read |=> rdata == $past(wdata, 3))
        else $error("upper address readback mismatch");
    AST_ADDR_LO_RW: assert property (s_lo_write ##2 s_lo_read
        |=> rdata == ($past(wdata, 3) & 32'hfffffffc))
        else $error("low address readback mismatch");
    AST_PAYLOAD_RW: assert property (s_pl_write ##2 s_pl_read
        |=> ((rdata ^ $past(wdata, 3)) & 32'h0000ffff) == 32'h0)
        else $error("message data readback mismatch");
    AST_AER_VER: assert property (rd && addr == AER_HDR_OFF |=> rdata[19:16] == 4'h1)
        else $error("error capability version wrong");
    AST_AER_NEXT: assert property (rd && addr == AER_HDR_OFF |=> rdata[31:20] == 12'h150)
        else $error("error capability next pointer wrong");
    AST_RDATA_IDLE: assert property (!rd |=> rdata == 32'h0)
        else $error("read data outside the read answer cycle");
    AST_MME_LEGAL: assert property (s_q.mme <= 3'h5)
        else $error("reserved allocation code held");
    AST_PAYLOAD_UPPER: assert property (rd && addr == PAYLOAD_OFF |=> rdata[31:16] == 16'h0)
        else $error("message data upper half not zero");
    AST_AER_HDR: assert property (rd && addr == AER_HDR_OFF |=> rdata == 32'h15010001)
        else $error("error capability header wrong");
    AST_UE_RESERVED: assert property ((s_q.ue_stat & ~UE_VALID) == 32'h0)
        else $error("reserved uncorrectable status bit set");
    AST_UE_SET_WINS: assert property (ue_set != 32'h0 |=> (s_q.ue_stat & $past(ue_set)) == $past(ue_set))
        else $error("uncorrectable event lost");
    AST_CE_RESERVED: assert property ((s_q.ce_stat & ~CE_VALID) == 32'h0)
        else $error("reserved correctable status bit set");
    AST_MASK_RESERVED: assert property ((s_q.ue_mask & ~UE_VALID) == 32'h0)
        else $error("reserved mask bit set");
    AST_CE_W1C: assert property (wr && !warm_rst && addr == CE_STAT_OFF && ce_set == 32'h0
        |=> s_q.ce_stat == $past(ce_clr_expect))
        else $error("correctable write one clear misbehaved");
    AST_UE_W1C: assert property (wr && !warm_rst && addr == UE_STAT_OFF && ue_set == 32'h0
        |=> s_q.ue_stat == $past(ue_clr_expect))
        else $error("write one clear misbehaved");
    AST_MASK_SILENT: assert property (ue_set != 32'h0 && ue_report == 32'h0
        |=> !err_fatal && !err_nonfatal)
        else $error("masked error reported");
    AST_FATAL_SEV: assert property ((ue_report & s_q.ue_sev) != 32'h0 |=> err_fatal)
        else $error("fatal severity not reported");
    AST_NONFATAL_SEV: assert property ((ue_report & ~s_q.ue_sev) != 32'h0 |=> err_nonfatal)
        else $error("non-fatal severity not reported");
    AST_WARM_CLEARS: assert property (warm_rst |=> s_q.addr_hi == 32'h0 && !s_q.msi_en)
        else $error("non-sticky register kept through warm reset");
    AST_CE_REPORT: assert property (ce_set != 32'h0 |=> err_corr && s_q.ce_stat != 32'h0)
        else $error("correctable error not recorded");
    AST_STICKY_WARM: assert property (warm_rst && !wr |=> $stable(s_q.ue_mask)
        && $stable(s_q.ue_sev))
        else $error("sticky register lost on warm reset");
    AST_MSG_REQ: assert property ($rose(trig) && !req_if.req |=> req_if.req ##1 mw_valid)
        else $error("interrupt did not start a message");
endmodule : msi_and_error_report_regs
`default_nettype wire

// >>> verif/msg_sink.sv
// Upstream completer model that accepts interrupt message writes
`default_nettype none
module msg_sink
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [3:0]  stall,
    input  wire logic        mw_valid,
    input  wire logic [63:0] mw_addr,
    input  wire logic [31:0] mw_data,
    output logic             mw_ready,
    output logic [7:0]       n_msg,
    output logic [63:0]      last_addr,
    output logic [31:0]      last_data
);
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed
    {
        logic        rdy;
        logic [3:0]  wait_n;
        logic [7:0]  cnt;
        logic [63:0] addr;
        logic [31:0] data;
    } sink_t;

    sink_t s_q;
    sink_t s_d;

    always_comb
    begin
        s_d     = s_q;
        s_d.rdy = 1'b0;
        if (mw_valid && s_q.rdy)
        begin
            // Accepted write is logged for the bench
            s_d.cnt    = s_q.cnt + 8'h01;
            s_d.addr   = mw_addr;
            s_d.data   = mw_data;
            s_d.wait_n = 4'h0;
        end
        else if (mw_valid)
        begin
            // Slow completer: ready only after stall+1 waiting cycles
            s_d.rdy    = (s_q.wait_n == stall);
            s_d.wait_n = s_q.wait_n + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign mw_ready  = s_q.rdy;
    assign n_msg     = s_q.cnt;
    assign last_addr = s_q.addr;
    assign last_data = s_q.data;
endmodule : msg_sink
`default_nettype wire

// >>> verif/tb_msi_and_error_report_regs.sv
// Self-checking bench for the interrupt-message and error-reporting registers
`default_nettype none
module tb_msi_and_error_report_regs import msi_aer_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic              clk, rst_b, warm_rst, wr, rd;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata, rdata, ue_event, ce_event, mw_data, last_data;
    logic              err_fatal, err_nonfatal, err_corr;
    logic              intx_in_b, intx_out_b, irq, mw_valid, mw_ready;
    logic [63:0]       mw_addr, last_addr;
    logic [3:0]        stall;
    logic [7:0]        n_msg;
    int                n_errors = 0;
    int                num_checks = 0;

    logic [11:0] reg_a [10] = '{MSG_CTRL_OFF, ADDR_LO_OFF, ADDR_HI_OFF, PAYLOAD_OFF,
        AER_HDR_OFF, UE_STAT_OFF, UE_MASK_OFF, UE_SEV_OFF, CE_STAT_OFF, 12'h1e0};
    logic [31:0] rst_v [10] = '{32'h00800005, 32'h0, 32'h0, 32'h0, 32'h15010001,
        32'h0, 32'h0, 32'h00062011, 32'h0, 32'h0};
    logic [31:0] ones_v [10] = '{32'h00810005, 32'hfffffffc, 32'hffffffff, 32'h0000ffff,
        32'h15010001, 32'h0, 32'h001ff011, 32'h001ff011, 32'h0, 32'h0};

    msi_and_error_report_regs uut
    (
        .clk, .rst_b, .warm_rst, .addr, .wdata, .wr, .rd, .rdata, .ue_event, .ce_event,
        .err_fatal, .err_nonfatal, .err_corr, .intx_in_b, .intx_out_b, .irq,
        .mw_valid, .mw_ready, .mw_addr, .mw_data
    );

    msg_sink sink
    (
        .clk, .rst_b, .stall, .mw_valid, .mw_addr, .mw_data, .mw_ready, .n_msg,
        .last_addr, .last_data
    );

    task automatic end_sim;
        $display("Checks %0d, errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
        begin
            $display("Regression OK");
        end
        else
        begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe, so sample there
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 check(64'(rdata), 64'(exp));
    endtask : rd_chk

    task automatic pulse(input logic [31:0] ue, input logic [31:0] ce, input logic [2:0] exp);
        @(posedge clk);
        ue_event <= ue;
        ce_event <= ce;
        @(posedge clk);
        ue_event <= '0;
        ce_event <= '0;
        #1 check(64'({err_fatal, err_nonfatal, err_corr}), 64'(exp));
    endtask : pulse

    task automatic wait_msg(input logic [7:0] n);
        for (int i = 0; i < 60 && n_msg !== n; i++)
        begin
            @(posedge clk);
        end
        if (n_msg !== n)
        begin
            n_errors++;
            end_sim();
        end
    endtask : wait_msg

    initial
    begin
        clk = 1'b0;
        forever
        begin
            #10 clk = ~clk;
        end
    end

    initial
    begin
        #1ms;
        n_errors++;
        end_sim();
    end

    initial
    begin
        rst_b     = 1'b0;
        warm_rst  = 1'b0;
        addr      = '0;
        wdata     = '0;
        wr        = 1'b0;
        rd        = 1'b0;
        ue_event  = '0;
        ce_event  = '0;
        intx_in_b = 1'b1;
        stall     = 4'h0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 10; i++)
        begin
            rd_chk(reg_a[i], rst_v[i]);
            wr_reg(reg_a[i], 32'hffffffff);
            rd_chk(reg_a[i], ones_v[i]);
            wr_reg(reg_a[i], rst_v[i]);
            rd_chk(reg_a[i], rst_v[i]);
        end
        // Reserved allocation codes must leave the previous code in place
        for (int c = 0; c < 8; c++)
        begin
            wr_reg(MSG_CTRL_OFF, {8'h00, 1'b1, 3'(c), 3'h7, 1'b0, 16'h0000});
            rd_chk(MSG_CTRL_OFF, {8'h00, 1'b1, (c > 5) ? 3'h5 : 3'(c), 20'h00005});
        end
        wr_reg(UE_MASK_OFF, 32'h00000010);
        wr_reg(IRQ_EN_OFF, 32'h00000003);
        pulse(32'h00000001, '0, 3'b100);
        pulse(32'h00001000, '0, 3'b010);
        pulse(32'h00000012, '0, 3'b000);
        pulse('0, 32'h00000042, 3'b001);
        rd_chk(UE_STAT_OFF, 32'h00001011);
        rd_chk(CE_STAT_OFF, 32'h00000040);
        rd_chk(IRQ_STAT_OFF, 32'h00000003);
        check(64'(irq), 64'h1);
        wr_reg(UE_STAT_OFF, 32'h00000001);
        rd_chk(UE_STAT_OFF, 32'h00001010);
        wr_reg(CE_STAT_OFF, 32'h00000040);
        rd_chk(CE_STAT_OFF, 32'h00000000);
        wr_reg(IRQ_EN_OFF, 32'h00000001);
        wr_reg(IRQ_CLR_OFF, 32'h00000001);
        #1 check(64'(irq), 64'h0);
        wr_reg(IRQ_EN_OFF, 32'h00000002);
        #1 check(64'(irq), 64'h1);
        wr_reg(IRQ_CLR_OFF, 32'h00000007);
        rd_chk(IRQ_STAT_OFF, 32'h00000000);
        // Warm reset keeps the sticky error state only
        wr_reg(ADDR_HI_OFF, 32'h0000abcd);
        warm_rst <= 1'b1;
        @(posedge clk);
        warm_rst <= 1'b0;
        rd_chk(ADDR_HI_OFF, 32'h00000000);
        rd_chk(UE_STAT_OFF, 32'h00001010);
        rd_chk(UE_MASK_OFF, 32'h00000010);
        // Legacy mode: interrupt goes to the pin, never to a message
        wr_reg(IRQ_EN_OFF, 32'h00000001);
        pulse(32'h00000001, '0, 3'b100);
        repeat (5) @(posedge clk);
        check(64'(n_msg), 64'h0);
        check(64'(intx_out_b), 64'h0);
        wr_reg(IRQ_CLR_OFF, 32'h00000007);
        intx_in_b <= 1'b0;
        repeat (4) @(posedge clk);
        #1 check(64'(intx_out_b), 64'h0);
        wr_reg(MSG_CTRL_OFF, 32'h00810000);
        #1 check(64'(intx_out_b), 64'h1);
        intx_in_b <= 1'b1;
        // Message mode with a slow completer, then a prompt one with 32-bit address
        wr_reg(ADDR_LO_OFF, 32'h12345678);
        wr_reg(ADDR_HI_OFF, 32'h9abcdef0);
        wr_reg(PAYLOAD_OFF, 32'hffff4321);
        stall <= 4'h3;
        pulse(32'h00002000, '0, 3'b100);
        wait_msg(8'h01);
        check(last_addr, 64'h9abcdef0_12345678);
        check(64'(last_data), 64'h4321);
        rd_chk(IRQ_STAT_OFF, 32'h00000005);
        wr_reg(IRQ_CLR_OFF, 32'h00000007);
        wr_reg(MSG_CTRL_OFF, 32'h00010000);
        stall <= 4'h0;
        pulse(32'h00002000, '0, 3'b100);
        wait_msg(8'h02);
        check(last_addr, 64'h00000000_12345678);
        end_sim();
    end
endmodule : tb_msi_and_error_report_regs
`default_nettype wire
